//--- rtl/crm_core_regs.sv
// Core register model: banks, accumulators, counters, ALU and status word
//
// Notes on behaviour
// - Main and alternate banks of six registers
// - Swap-all exchanges BC, DE, HL pairs
// - Swap-HL exchanges only the HL pair
// - Swap-accumulators exchanges VA and wide accumulator
// - Working address is vector high, immediate low
// - DE/HL indirect step +1, -1 or +2
// - Program counter advances, loads, resets zero
// - Stack pointer down on push, up on pop
// - ALU byte/word ops, rotate, multiply, divide
// - Status bit layout, bits 7,1 zero
// - Interrupt entry pushes status, return restores
// - Reset clears the status word
// - Zero flag follows result when affected
// - Half carry from bit 3
// - Carry from bit 7 or bit 15
// - Load-chain flags set on stacked loads
// - Skip flag follows the skip condition
// - Fixed interrupt vectors
// - Table call 32 entries at 0080H-00BFH
// - Fixed-area call reaches 0800H-0FFFH
// - Internal RAM at FC00H-FFFFH
// - ROM or external placement per variant
// - RAM enable bit gates internal RAM
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps

module crm_core_regs
	import crm_pkg::*;
#(
	parameter bit HAS_ROM = 1'b1
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Status
	output logic             core_busy,
	output logic      [15:0] mem_addr,
	output logic      [1:0]  mem_region
);

	// The whole model is one packed word: one process works out the next
	// value and one process registers it
	typedef struct packed {
		logic [15:0] bc, de, hl, bc_alt, de_alt, hl_alt;
		logic [15:0] va, va_alt;       // V high, A low
		logic [15:0] wacc, wacc_alt;
		logic [15:0] pc, sp;
		logic [7:0]  program_status_flags;
		logic [7:0]  mmap;
		logic [15:0] opa, opb;
		logic [15:0] result, addr;
		logic [1:0]  region;
		logic [15:0] stack_psw;        // Pushed operand or saved status
		logic [4:0]  div_cnt;
		logic [15:0] div_rem;
		logic [15:0] div_quo;
		logic [7:0]  div_dvs;
		logic [31:0] rdata;
		logic        busy;           // Division running, as a plain bit
	} crm_state_s;

	crm_state_s st_reg, st_next;

	// Memory region of an address under the current mapping
	// RAM is tested first: its window lies above the ROM ceiling and
	// falls back to external memory while disabled
	function automatic logic [1:0] crm_region(input logic [15:0] a,
		input logic internal_ram_enable);
		if (a >= CRM_RAM_LO && internal_ram_enable)
			return CRM_RGN_RAM;
		else if (HAS_ROM && a <= CRM_ROM_HI)
			return CRM_RGN_ROM;
		else
			return CRM_RGN_EXT;
	endfunction

	// Byte add/subtract with half carry and carry
	// The low nibble is worked apart, which gives the half carry directly
	function automatic logic [9:0] crm_add8(input logic [7:0] x,
		input logic [7:0] y, input logic sub);
		logic [4:0] lo;
		logic [8:0] full;
		lo   = sub ? ({1'b0, x[3:0]} - {1'b0, y[3:0]})
			: ({1'b0, x[3:0]} + {1'b0, y[3:0]});
		full = sub ? ({1'b0, x} - {1'b0, y}) : ({1'b0, x} + {1'b0, y});
		return {lo[4], full};
	endfunction

	// Shared arithmetic, worked every cycle whether used or not
	logic [9:0]  add8;
	logic [16:0] add16;
	logic [4:0]  cmd;
	logic [15:0] vec;
	logic [15:0] ind_ptr;
	logic [16:0] div_trial;

	// Next state of the whole model
	// Defaults hold every field; read data fall back to zero
	always_comb begin
		st_next = st_reg;
		st_next.rdata = 32'h00000000;
		// Command field; the pc step length rides in bits 10:8
		cmd = reg_wdata[4:0];
		add8 = crm_add8(st_reg.va[7:0], st_reg.opa[7:0],
			cmd == CRM_OP_SUB);
		// Word add/subtract; bit 16 is the carry out of bit 15
		add16 = (cmd == CRM_OP_WSUB)
			? ({1'b0, st_reg.wacc} - {1'b0, st_reg.opa})
			: ({1'b0, st_reg.wacc} + {1'b0, st_reg.opa});
		// Interrupt source selects a fixed vector
		vec = CRM_VEC_NMI;
		case (st_reg.opb[2:0])
			3'h1: vec = CRM_VEC_TMR;
			3'h2: vec = CRM_VEC_EXT;
			3'h3: vec = CRM_VEC_CNT;
			3'h4: vec = CRM_VEC_CNAD;
			3'h5: vec = CRM_VEC_SER;
			3'h6: vec = CRM_VEC_SOFT;
			default: vec = CRM_VEC_NMI;
		endcase
		// Pointer for indirect access: HL when OPB bit 2 is set, else DE
		ind_ptr = st_reg.opb[2] ? st_reg.hl : st_reg.de;
		// Trial subtract from the remainder shifted left, with the next
		// dividend bit brought in from the top of div_quo
		div_trial = {st_reg.div_rem, st_reg.div_quo[15]}
			- {9'h000, st_reg.div_dvs};

		// Division runs one quotient bit per cycle; restoring form keeps
		// the datapath to one subtractor at the cost of sixteen cycles
		if (st_reg.div_cnt != 5'h00) begin
			st_next.div_cnt = st_reg.div_cnt - 5'h01;
			if (!div_trial[16]) begin
				st_next.div_rem = div_trial[15:0];
				st_next.div_quo = {st_reg.div_quo[14:0], 1'b1};
			end else begin
				st_next.div_rem = {st_reg.div_rem[14:0],
					st_reg.div_quo[15]};
				st_next.div_quo = {st_reg.div_quo[14:0], 1'b0};
			end
			// Last step: quotient to the wide accumulator, remainder out
			if (st_reg.div_cnt == 5'h01) begin
				st_next.wacc = st_next.div_quo;
				st_next.result = st_next.div_rem;
			end
		end

		// Register port writes; commands are ignored while dividing
		if (reg_wr) begin
			case (reg_addr)
				CRM_OFS_OPA:  st_next.opa  = reg_wdata[15:0];
				CRM_OFS_OPB:  st_next.opb  = reg_wdata[15:0];
				CRM_OFS_PC:   st_next.pc   = reg_wdata[15:0];
				CRM_OFS_SP:   st_next.sp   = reg_wdata[15:0];
				CRM_OFS_PSW:  st_next.program_status_flags  = reg_wdata[7:0] & CRM_PSW_MASK;
				CRM_OFS_BC:   st_next.bc   = reg_wdata[15:0];
				CRM_OFS_DE:   st_next.de   = reg_wdata[15:0];
				CRM_OFS_HL:   st_next.hl   = reg_wdata[15:0];
				CRM_OFS_VA:   st_next.va   = reg_wdata[15:0];
				CRM_OFS_WACC: st_next.wacc = reg_wdata[15:0];
				CRM_OFS_MMAP: st_next.mmap = reg_wdata[7:0];
				CRM_OFS_CMD: if (st_reg.div_cnt == 5'h00) begin
					// Load-chain flags drop on every other command
					st_next.program_status_flags[CRM_PSW_L1] = 1'b0;
					st_next.program_status_flags[CRM_PSW_L0] = 1'b0;
					st_next.program_status_flags[CRM_PSW_SK] = 1'b0;
					case (cmd)
						// Swaps move whole pairs in one cycle, no memory
						CRM_OP_SWAP_ALL: begin
							st_next.bc = st_reg.bc_alt;
							st_next.bc_alt = st_reg.bc;
							st_next.de = st_reg.de_alt;
							st_next.de_alt = st_reg.de;
							st_next.hl = st_reg.hl_alt;
							st_next.hl_alt = st_reg.hl;
						end
						CRM_OP_SWAP_HL: begin
							st_next.hl = st_reg.hl_alt;
							st_next.hl_alt = st_reg.hl;
						end
						CRM_OP_SWAP_ACC: begin
							st_next.va = st_reg.va_alt;
							st_next.va_alt = st_reg.va;
							st_next.wacc = st_reg.wacc_alt;
							st_next.wacc_alt = st_reg.wacc;
						end
						// Byte arithmetic: zero, half carry and carry
						CRM_OP_ADD, CRM_OP_SUB: begin
							st_next.va[7:0] = add8[7:0];
							st_next.program_status_flags[CRM_PSW_Z]  = add8[7:0] == 8'h00;
							st_next.program_status_flags[CRM_PSW_HC] = add8[9];
							st_next.program_status_flags[CRM_PSW_CY] = add8[8];
						end
						CRM_OP_AND, CRM_OP_OR, CRM_OP_XOR: begin
							// Logic ops leave half carry and carry alone
							st_next.va[7:0] = (cmd == CRM_OP_AND)
								? (st_reg.va[7:0] & st_reg.opa[7:0])
								: (cmd == CRM_OP_OR)
								? (st_reg.va[7:0] | st_reg.opa[7:0])
								: (st_reg.va[7:0] ^ st_reg.opa[7:0]);
							st_next.program_status_flags[CRM_PSW_Z] =
								st_next.va[7:0] == 8'h00;
						end
						CRM_OP_WADD, CRM_OP_WSUB: begin
							st_next.wacc = add16[15:0];
							st_next.program_status_flags[CRM_PSW_Z]  = add16[15:0] == 16'h0000;
							st_next.program_status_flags[CRM_PSW_CY] = add16[16];
						end
						CRM_OP_RLL: begin             // Rotate through carry
							st_next.va[7:0] = {st_reg.va[6:0],
								st_reg.program_status_flags[CRM_PSW_CY]};
							st_next.program_status_flags[CRM_PSW_CY] = st_reg.va[7];
						end
						CRM_OP_RLR: begin
							st_next.va[7:0] = {st_reg.program_status_flags[CRM_PSW_CY],
								st_reg.va[7:1]};
							st_next.program_status_flags[CRM_PSW_CY] = st_reg.va[0];
						end
						// Shift left fills a zero, old bit 7 to carry
						CRM_OP_SLL: begin
							st_next.va[7:0] = {st_reg.va[6:0], 1'b0};
							st_next.program_status_flags[CRM_PSW_CY] = st_reg.va[7];
						end
						CRM_OP_MUL:
							// Widened first: product keeps 16 bits
							st_next.wacc = {8'h00, st_reg.va[7:0]}
								* {8'h00, st_reg.opa[7:0]};
						// Dividend rides in div_quo, shifted out
						CRM_OP_DIV: begin
							st_next.div_cnt = CRM_DIV_STEPS;
							st_next.div_rem = 16'h0000;
							st_next.div_quo = st_reg.wacc;
							st_next.div_dvs = st_reg.opa[7:0];
						end
						CRM_OP_ADV_PC:
							st_next.pc = st_reg.pc + {13'h0000, reg_wdata[10:8]};
						// Branch loads the counter from the operand
						CRM_OP_JUMP: st_next.pc = st_reg.opa;
						CRM_OP_PUSH: begin
							st_next.sp = st_reg.sp - CRM_STEP2;
							st_next.stack_psw = st_reg.opa;
							// One save slot: a new push overwrites it
						end
						CRM_OP_POP: begin
							st_next.sp = st_reg.sp + CRM_STEP2;
							st_next.result = st_reg.stack_psw;
						end
						CRM_OP_INTR: begin
							st_next.sp = st_reg.sp - CRM_STEP2;
							// Status before this command's flag clear
							st_next.stack_psw = {8'h00, st_reg.program_status_flags};
							st_next.pc = vec;
						end
						CRM_OP_INTERRUPT_RETURN: begin
							st_next.sp = st_reg.sp + CRM_STEP2;
							// Reserved bits stay zero whatever was saved
							st_next.program_status_flags = st_reg.stack_psw[7:0] & CRM_PSW_MASK;
						end
						CRM_OP_TCALL: begin
							st_next.sp = st_reg.sp - CRM_STEP2;
							st_next.addr = CRM_TCALL_BASE
								+ {10'h000, st_reg.opa[4:0], 1'b0};
							// Entry address also goes to mem_addr
							st_next.pc = st_next.addr;
						end
						CRM_OP_FCALL: begin
							st_next.sp = st_reg.sp - CRM_STEP2;
							// Any target in the fixed area, one step
							st_next.pc = CRM_FCALL_BASE
								| {5'h00, st_reg.opa[10:0] & CRM_FCALL_MASK};
						end
						CRM_OP_WORK:
							// Vector register picks the 256-byte page
							st_next.addr = {st_reg.va[15:8], st_reg.opa[7:0]};
						CRM_OP_IND: begin
							// Address takes the pointer before its step
							st_next.addr = ind_ptr;
							case (st_reg.opb[1:0])
								CRM_IND_INC1: ind_ptr = ind_ptr + CRM_STEP1;
								CRM_IND_DEC1: ind_ptr = ind_ptr - CRM_STEP1;
								CRM_IND_INC2: ind_ptr = ind_ptr + CRM_STEP2;
								default: ind_ptr = ind_ptr;
							endcase
							if (st_reg.opb[2])
								st_next.hl = ind_ptr;
							else
								st_next.de = ind_ptr;
						end
						CRM_OP_LDI_A: begin
							// Stackable loads set their chain flag
							st_next.va[7:0] = st_reg.opa[7:0];
							st_next.program_status_flags[CRM_PSW_L1] = 1'b1;
						end
						CRM_OP_LDI_L: begin
							st_next.hl[7:0] = st_reg.opa[7:0];
							st_next.program_status_flags[CRM_PSW_L0] = 1'b1;
						end
						CRM_OP_SKIPTST:
							// Skip when the masked bits are all zero
							st_next.program_status_flags[CRM_PSW_SK] =
								(st_reg.va[7:0] & st_reg.opa[7:0]) == 8'h00;
						CRM_OP_STC: st_next.program_status_flags[CRM_PSW_CY] = 1'b1;
						CRM_OP_CLC: st_next.program_status_flags[CRM_PSW_CY] = 1'b0;
						default: st_next.program_status_flags = st_next.program_status_flags;
					endcase
				end
				// Unmapped offsets and read-only registers ignore writes
				default: st_next.opa = st_next.opa;
			endcase
		end

		// Memory region of the last formed address
		// Worked from next values so region and address move together
		st_next.region = crm_region(st_next.addr,
			st_next.mmap[CRM_MM_RAE]);

		// Busy kept as its own bit so the output needs no decode
		st_next.busy = st_next.div_cnt != 5'h00;

		// Read data stand in the cycle after the strobe
		// and drop back to zero, so a stale word is never seen twice
		if (reg_rd) begin
			case (reg_addr)
				CRM_OFS_OPA:    st_next.rdata = {16'h0000, st_reg.opa};
				CRM_OFS_OPB:    st_next.rdata = {16'h0000, st_reg.opb};
				CRM_OFS_PC:     st_next.rdata = {16'h0000, st_reg.pc};
				CRM_OFS_SP:     st_next.rdata = {16'h0000, st_reg.sp};
				CRM_OFS_PSW:    st_next.rdata = {24'h000000,
					st_reg.program_status_flags & CRM_PSW_MASK};
				CRM_OFS_RESULT: st_next.rdata = {16'h0000, st_reg.result};
				CRM_OFS_ADDR:   st_next.rdata = {16'h0000, st_reg.addr};
				CRM_OFS_BC:     st_next.rdata = {16'h0000, st_reg.bc};
				CRM_OFS_DE:     st_next.rdata = {16'h0000, st_reg.de};
				CRM_OFS_HL:     st_next.rdata = {16'h0000, st_reg.hl};
				CRM_OFS_VA:     st_next.rdata = {16'h0000, st_reg.va};
				CRM_OFS_WACC:   st_next.rdata = {16'h0000, st_reg.wacc};
				CRM_OFS_MMAP:   st_next.rdata = {24'h000000, st_reg.mmap};
				CRM_OFS_REGION: st_next.rdata = {30'h00000000, st_reg.region};
				CRM_OFS_CMD:    st_next.rdata = {31'h00000000,
					st_reg.div_cnt != 5'h00};
				default:        st_next.rdata = 32'h00000000;
			endcase
		end
	end

	// State register; reset clears counters and status
	// Reset loads constants only; named fields repeat the cleared value
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg <= '0;
			st_reg.pc  <= CRM_PC_RST;
			st_reg.sp  <= CRM_SP_RST;
			st_reg.program_status_flags <= CRM_PSW_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops; no decode reaches the pins
	assign reg_rdata  = st_reg.rdata;
	assign core_busy  = st_reg.busy;
	assign mem_addr   = st_reg.addr;
	assign mem_region = st_reg.region;

endmodule

//--- rtl/crm_pkg.sv
// Package: constants and types of the core register model
package crm_pkg;

	// Register port offsets (byte addresses)
	localparam logic [7:0] CRM_OFS_CMD      = 8'h00;
	localparam logic [7:0] CRM_OFS_OPA      = 8'h04;
	localparam logic [7:0] CRM_OFS_OPB      = 8'h08;
	localparam logic [7:0] CRM_OFS_PC       = 8'h0C;
	localparam logic [7:0] CRM_OFS_SP       = 8'h10;
	localparam logic [7:0] CRM_OFS_PSW      = 8'h14;
	localparam logic [7:0] CRM_OFS_RESULT   = 8'h18;
	localparam logic [7:0] CRM_OFS_ADDR     = 8'h1C;
	localparam logic [7:0] CRM_OFS_BC       = 8'h20;
	localparam logic [7:0] CRM_OFS_DE       = 8'h24;
	localparam logic [7:0] CRM_OFS_HL       = 8'h28;
	localparam logic [7:0] CRM_OFS_VA       = 8'h2C;
	localparam logic [7:0] CRM_OFS_WACC     = 8'h30;
	localparam logic [7:0] CRM_OFS_MMAP     = 8'h34;
	localparam logic [7:0] CRM_OFS_REGION   = 8'h38;

	// Status word bit positions
	localparam int CRM_PSW_Z  = 6;
	localparam int CRM_PSW_SK = 5;
	localparam int CRM_PSW_HC = 4;
	localparam int CRM_PSW_L1 = 3;
	localparam int CRM_PSW_L0 = 2;
	localparam int CRM_PSW_CY = 0;
	localparam logic [7:0] CRM_PSW_MASK = 8'h7D;
	localparam int CRM_MM_RAE = 3;

	// Reset values
	localparam logic [15:0] CRM_PC_RST  = 16'h0000;
	localparam logic [15:0] CRM_SP_RST  = 16'h0000;
	localparam logic [7:0]  CRM_PSW_RST = 8'h00;

	// Fixed vectors and tables
	localparam logic [15:0] CRM_VEC_NMI   = 16'h0004;
	localparam logic [15:0] CRM_VEC_TMR   = 16'h0008;
	localparam logic [15:0] CRM_VEC_EXT   = 16'h0010;
	localparam logic [15:0] CRM_VEC_CNT   = 16'h0018;
	localparam logic [15:0] CRM_VEC_CNAD  = 16'h0020;
	localparam logic [15:0] CRM_VEC_SER   = 16'h0028;
	localparam logic [15:0] CRM_VEC_SOFT  = 16'h0060;
	localparam logic [15:0] CRM_TCALL_BASE = 16'h0080;
	localparam logic [15:0] CRM_FCALL_BASE = 16'h0800;
	localparam logic [10:0] CRM_FCALL_MASK = 11'h7FF;

	// Memory map limits
	localparam logic [15:0] CRM_RAM_LO = 16'hFC00;
	localparam logic [15:0] CRM_ROM_HI = 16'h7FFF;

	// Memory region codes
	localparam logic [1:0] CRM_RGN_ROM = 2'h0;
	localparam logic [1:0] CRM_RGN_EXT = 2'h1;
	localparam logic [1:0] CRM_RGN_RAM = 2'h2;

	// Command codes (CMD register bits 4:0)
	typedef enum logic [4:0] {
		CRM_OP_NOP      = 5'h00,
		CRM_OP_SWAP_ALL = 5'h01,
		CRM_OP_SWAP_HL  = 5'h02,
		CRM_OP_SWAP_ACC = 5'h03,
		CRM_OP_ADD      = 5'h04,
		CRM_OP_SUB      = 5'h05,
		CRM_OP_AND      = 5'h06,
		CRM_OP_OR       = 5'h07,
		CRM_OP_XOR      = 5'h08,
		CRM_OP_WADD     = 5'h09,
		CRM_OP_WSUB     = 5'h0A,
		CRM_OP_RLL      = 5'h0B,
		CRM_OP_RLR      = 5'h0C,
		CRM_OP_SLL      = 5'h0D,
		CRM_OP_MUL      = 5'h0E,
		CRM_OP_DIV      = 5'h0F,
		CRM_OP_ADV_PC   = 5'h10,
		CRM_OP_JUMP     = 5'h11,
		CRM_OP_PUSH     = 5'h12,
		CRM_OP_POP      = 5'h13,
		CRM_OP_INTR     = 5'h14,
		CRM_OP_INTERRUPT_RETURN     = 5'h15,
		CRM_OP_TCALL    = 5'h16,
		CRM_OP_FCALL    = 5'h17,
		CRM_OP_WORK     = 5'h18,
		CRM_OP_IND      = 5'h19,
		CRM_OP_LDI_A    = 5'h1A,
		CRM_OP_LDI_L    = 5'h1B,
		CRM_OP_SKIPTST  = 5'h1C,
		CRM_OP_STC      = 5'h1D,
		CRM_OP_CLC      = 5'h1E
	} crm_op_e;

	// Indirect modes (OPB bits 1:0)
	localparam logic [1:0] CRM_IND_INC1 = 2'h1;
	localparam logic [1:0] CRM_IND_DEC1 = 2'h2;
	localparam logic [1:0] CRM_IND_INC2 = 2'h3;
	localparam logic [15:0] CRM_STEP1 = 16'h0001;
	localparam logic [15:0] CRM_STEP2 = 16'h0002;

	// Division busy count: one cycle per quotient bit
	localparam logic [4:0] CRM_DIV_STEPS = 5'h10;

endpackage

//--- verif/crm_core_regs_props.sv
// Checker: port-level properties of the core register model
`timescale 1ns/1ps
module crm_core_regs_props
	import crm_pkg::*;
#(
	parameter bit HAS_ROM = 1'b1
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Status
	input wire logic        core_busy,
	input wire logic [15:0] mem_addr,
	input wire logic [1:0]  mem_region
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	logic [7:0] opa_reg;
	logic       cmd_ok;
	////////////////////////////////////////////////////////////////////////////
	// Operand shadow, since the formed addresses depend on it
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) opa_reg <= 8'h00;
		else if (reg_wr && reg_addr == CRM_OFS_OPA) opa_reg <= reg_wdata[7:0];
	end
	// A command is only taken while no division runs
	assign cmd_ok = reg_wr && reg_addr == CRM_OFS_CMD && !core_busy;
	////////////////////////////////////////////////////////////////////////////
	a_psw_reserved: assert property ($past(reg_rd) &&
		$past(reg_addr) == CRM_OFS_PSW |-> !reg_rdata[7] && !reg_rdata[1])
		else $error("status bits 7 or 1 read as one");
	a_div_start: assert property (
		cmd_ok && reg_wdata[4:0] == CRM_OP_DIV |=> core_busy)
		else $error("division did not start");
	a_div_length: assert property (
		$rose(core_busy) |-> ##15 core_busy ##1 !core_busy)
		else $error("division busy length wrong");
	a_rom_low: assert property (
		HAS_ROM && mem_addr <= CRM_ROM_HI |-> mem_region == CRM_RGN_ROM)
		else $error("low address not in internal ROM");
	a_ram_high: assert property (
		mem_region == CRM_RGN_RAM |-> mem_addr >= CRM_RAM_LO)
		else $error("internal RAM below its base");
	a_ext_mid: assert property (
		mem_addr > CRM_ROM_HI && mem_addr < CRM_RAM_LO
		|-> mem_region == CRM_RGN_EXT)
		else $error("middle address not external");
	a_tcall_addr: assert property (
		cmd_ok && reg_wdata[4:0] == CRM_OP_TCALL
		|=> mem_addr == CRM_TCALL_BASE + {10'h000, opa_reg[4:0], 1'b0})
		else $error("table call entry address wrong");
	a_work_low: assert property (
		cmd_ok && reg_wdata[4:0] == CRM_OP_WORK |=> mem_addr[7:0] == opa_reg)
		else $error("working address low byte wrong");
endmodule

bind crm_core_regs crm_core_regs_props #(.HAS_ROM(HAS_ROM)) i_crm_core_regs_props (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .core_busy(core_busy), .mem_addr(mem_addr),
	.mem_region(mem_region));

//--- verif/crm_ext_mem.sv
// Partner model: which memory answers a formed address
`timescale 1ns/1ps
module crm_ext_mem
	import crm_pkg::*;
#(
	parameter bit HAS_ROM = 1'b1
) (
	// Address and RAM enable
	input  wire logic [15:0] bus_addr,
	input  wire logic        ram_en,
	// Answering memory
	output logic      [1:0]  answer_region
);
	// Disabled RAM leaves its window to the outside memory
	always_comb begin
		if (bus_addr >= CRM_RAM_LO && ram_en) begin
			answer_region = CRM_RGN_RAM;
		end else if (HAS_ROM && bus_addr <= CRM_ROM_HI) begin
			answer_region = CRM_RGN_ROM;
		end else begin
			answer_region = CRM_RGN_EXT;
		end
	end
endmodule

//--- verif/crm_core_regs_tb.sv
// Testbench: self-checking run of the core register model
`timescale 1ns/1ps
module crm_core_regs_tb
	import crm_pkg::*;
;
	logic        ref_clk, sys_rst, reg_wr, reg_rd, core_busy, ram_en;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] mem_addr;
	logic [1:0]  mem_region, exp_region;
	int          n_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	localparam logic [15:0] VEC [7] = '{CRM_VEC_NMI, CRM_VEC_TMR,
		CRM_VEC_EXT, CRM_VEC_CNT, CRM_VEC_CNAD, CRM_VEC_SER, CRM_VEC_SOFT};
	crm_core_regs #(.HAS_ROM(1'b1)) i_crm_core_regs (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.core_busy(core_busy), .mem_addr(mem_addr), .mem_region(mem_region));
	crm_ext_mem #(.HAS_ROM(1'b1)) i_crm_ext_mem (.bus_addr(mem_addr),
		.ram_en(ram_en), .answer_region(exp_region));
	////////////////////////////////////////////////////////////////////////////
	// Clock, and a cycle ceiling well above the roughly 500 cycles used
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 8000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic final_report();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Bus cycles; a spare edge after each keeps strobes single-assigned
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata);
		@(posedge ref_clk);
	endtask
	task automatic cmd(input crm_op_e op, input logic [2:0] len = 3'h0);
		wr(CRM_OFS_CMD, {21'h0, len, 3'h0, op});
	endtask
	task automatic alu(input crm_op_e op, input logic [7:0] a, b, r, p, f);
		wr(CRM_OFS_PSW, {24'h0, p});
		wr(CRM_OFS_VA, {24'h0, a});
		wr(CRM_OFS_OPA, {24'h0, b});
		cmd(op);
		rc("acc", CRM_OFS_VA, {24'h0, r});
		rc("flags", CRM_OFS_PSW, {24'h0, f});
	endtask
	task automatic ind(input logic [7:0] r, input logic [15:0] s, n,
		input logic [2:0] m);
		wr(r, {16'h0, s});
		wr(CRM_OFS_OPB, {29'h0, m});
		cmd(CRM_OP_IND);
		rc("ptr addr", CRM_OFS_ADDR, {16'h0, s});
		rc("ptr step", r, {16'h0, n});
		#1 chk("region", {30'h0, exp_region}, {30'h0, mem_region});
		@(posedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rc("pc", CRM_OFS_PC, 32'h0);
		rc("sp", CRM_OFS_SP, 32'h0);
		rc("psw", CRM_OFS_PSW, 32'h0);
		rc("unmapped", 8'h3C, 32'h0);
		wr(CRM_OFS_PSW, 32'hFF);
		rc("psw mask", CRM_OFS_PSW, 32'h7D);
	endtask
	task automatic t_banks();
		wr(CRM_OFS_BC, 32'h1111);
		wr(CRM_OFS_DE, 32'h2222);
		wr(CRM_OFS_HL, 32'h3333);
		cmd(CRM_OP_SWAP_ALL);
		rc("bc alt", CRM_OFS_BC, 32'h0);
		cmd(CRM_OP_SWAP_HL);
		rc("hl swap", CRM_OFS_HL, 32'h3333);
		rc("de kept", CRM_OFS_DE, 32'h0);
		cmd(CRM_OP_SWAP_ALL);
		rc("de main", CRM_OFS_DE, 32'h2222);
		rc("hl alt", CRM_OFS_HL, 32'h0);
		wr(CRM_OFS_VA, 32'h1234);
		wr(CRM_OFS_WACC, 32'hBEEF);
		cmd(CRM_OP_SWAP_ACC);
		rc("wacc alt", CRM_OFS_WACC, 32'h0);
		cmd(CRM_OP_SWAP_ACC);
		rc("va main", CRM_OFS_VA, 32'h1234);
	endtask
	task automatic t_alu();
		alu(CRM_OP_ADD, 8'h0F, 8'h01, 8'h10, 8'h00, 8'h10);
		alu(CRM_OP_ADD, 8'hFF, 8'h01, 8'h00, 8'h00, 8'h51);
		alu(CRM_OP_SUB, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h11);
		alu(CRM_OP_AND, 8'hF0, 8'h0F, 8'h00, 8'h01, 8'h41);
		alu(CRM_OP_OR, 8'hF0, 8'h0F, 8'hFF, 8'h41, 8'h01);
		alu(CRM_OP_XOR, 8'h5A, 8'h5A, 8'h00, 8'h10, 8'h50);
		alu(CRM_OP_RLL, 8'h81, 8'h00, 8'h03, 8'h01, 8'h01);
		alu(CRM_OP_RLR, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01);
		alu(CRM_OP_SLL, 8'h81, 8'h00, 8'h02, 8'h40, 8'h41);
		alu(CRM_OP_SKIPTST, 8'h0F, 8'hF0, 8'h0F, 8'h00, 8'h20);
		alu(CRM_OP_SKIPTST, 8'h0F, 8'h01, 8'h0F, 8'h20, 8'h00);
		alu(CRM_OP_LDI_A, 8'h00, 8'h77, 8'h77, 8'h04, 8'h08);
		alu(CRM_OP_LDI_L, 8'h77, 8'h33, 8'h77, 8'h08, 8'h04);
		alu(CRM_OP_STC, 8'h01, 8'h00, 8'h01, 8'h2C, 8'h01);
		alu(CRM_OP_CLC, 8'h01, 8'h00, 8'h01, 8'h41, 8'h40);
		wr(CRM_OFS_VA, 32'hF0);
		wr(CRM_OFS_OPA, 32'h11);
		cmd(CRM_OP_MUL);
		rc("product", CRM_OFS_WACC, 32'h0FF0);
	endtask
	task automatic t_div();
		wr(CRM_OFS_PC, 32'h0100);
		wr(CRM_OFS_WACC, 32'h0064);
		wr(CRM_OFS_OPA, 32'h0007);
		cmd(CRM_OP_DIV);
		cmd(CRM_OP_ADV_PC, 3'h2);
		#1 for (int i = 0; i < 40 && core_busy !== 1'b0; i++) @(posedge ref_clk);
		#1 chk("busy", 32'h0, {31'h0, core_busy});
		@(posedge ref_clk);
		rc("pc refused", CRM_OFS_PC, 32'h0100);
		rc("quotient", CRM_OFS_WACC, 32'h000E);
		rc("remainder", CRM_OFS_RESULT, 32'h0002);
	endtask
	task automatic t_flow();
		wr(CRM_OFS_OPA, 32'h1234);
		cmd(CRM_OP_JUMP);
		cmd(CRM_OP_ADV_PC, 3'h3);
		rc("pc", CRM_OFS_PC, 32'h1237);
		wr(CRM_OFS_OPA, 32'hA5A5);
		cmd(CRM_OP_PUSH);
		rc("sp push", CRM_OFS_SP, 32'hFFFE);
		cmd(CRM_OP_POP);
		rc("sp pop", CRM_OFS_SP, 32'h0);
		rc("pop data", CRM_OFS_RESULT, 32'hA5A5);
		for (int i = 0; i < 7; i++) begin
			wr(CRM_OFS_OPB, 32'(i));
			wr(CRM_OFS_PSW, 32'h41);
			cmd(CRM_OP_INTR);
			rc("vector", CRM_OFS_PC, {16'h0, VEC[i]});
			rc("sp entry", CRM_OFS_SP, 32'hFFFE);
			wr(CRM_OFS_PSW, 32'h0);
			cmd(CRM_OP_INTERRUPT_RETURN);
			rc("psw back", CRM_OFS_PSW, 32'h41);
		end
		wr(CRM_OFS_OPA, 32'h1F);
		cmd(CRM_OP_TCALL);
		rc("tcall", CRM_OFS_PC, 32'h00BE);
		wr(CRM_OFS_OPA, 32'h07FF);
		cmd(CRM_OP_FCALL);
		rc("fcall", CRM_OFS_PC, 32'h0FFF);
	endtask
	task automatic t_mem();
		wr(CRM_OFS_VA, 32'hAB00);
		wr(CRM_OFS_OPA, 32'hCD);
		cmd(CRM_OP_WORK);
		rc("work", CRM_OFS_ADDR, 32'hABCD);
		ind(CRM_OFS_DE, 16'h7FFF, 16'h8000, 3'h1);
		ind(CRM_OFS_DE, 16'h8000, 16'h7FFF, 3'h2);
		ind(CRM_OFS_HL, 16'hFC00, 16'hFC02, 3'h7);
		wr(CRM_OFS_MMAP, 32'h8);
		ram_en = 1'b1;
		ind(CRM_OFS_HL, 16'hFBFF, 16'hFC00, 3'h5);
		ind(CRM_OFS_HL, 16'hFFFF, 16'hFFFE, 3'h6);
	endtask
	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		ram_en = 1'b0;
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_banks();
		t_alu();
		t_div();
		t_flow();
		t_mem();
		final_report();
	end
endmodule
